// ==== core/uabw_dev.sv ====
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// Behaviour
// - wake plus autobaud: measure byte after break
// - measuring counter starts at one
// - measure clock is base clock over eight
// - divisor pair forms one 16-bit counter
// - overflow flag when counter wraps early
// - after overflow count on to fifth edge
// - data read clears rx flag; overflow writable
// - overflow clear refused while autobaud enabled
// - wake only in asynchronous mode
// - wake armed: receiver idle, falling edge wakes
// - wake event raises receive flag
// - rising edge ends break, clears wake enable
// - nonzero char: first low is wake
// - node opens with long zero wake char
// - software checks receive idle before arming
// - break is start, twelve zeros, stop
// - data write with send-break starts break
// - send-break clears after stop bit
// - header is break then sync byte
// - transmit flag while data register empty
// - received break: flag, framing error, zero
// - shift-empty flag same during break
// - autobaud counts rising edges one to five
// - receiver idle during calibration
module uabw_dev
  import uabw_pkg::*;
(
  input  wire logic        core_clk,      // system clock
  input  wire logic        rst,           // sync reset, high
  input  wire logic        ce,            // clock enable
  input  wire logic [3:0]  avs_address,   // byte address
  input  wire logic        avs_read,      // read strobe
  input  wire logic        avs_write,     // write strobe
  input  wire logic [31:0] avs_writedata, // write data
  output logic [31:0]      avs_readdata,  // read data
  output logic             avs_waitrequest, // stall
  uabw_if.dev              lnk            // serial line
);
  // registers
  logic [7:0]  ctrl_r;
  logic        rxif_r, framing_error_flag_r, ovf_r, txif_r;
  logic [15:0] div_r;
  logic [7:0]  rxd_r, txbuf_r, tsr_r;
  logic        txbuf_full_r;
  logic        ack_r;
  logic        rx_s1_r, rx_s2_r, rx_prev_r;
  logic        send_brk_r;
  // transmitter state
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10,
                            TX_STOP = 2'b11} uabw_tx_t;
  uabw_tx_t    tx_st_r;
  logic [3:0]  tx_bits_r, tx_ph_r;
  logic        tx_brk_r;
  // receiver state
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
                            RX_STOP = 2'b11} uabw_rx_t;
  uabw_rx_t    rx_st_r;
  logic [3:0]  rx_bits_r, rx_ph_r;
  logic [7:0]  rsr_r;
  logic [2:0]  rise_r;
  logic        abd_run_r, abd_presc_wrap;
  logic [2:0]  abd_pre_r;
  logic        wake_hold_r;
  logic        bit_tick, rx_fall, rx_rise;
  logic [11:0] base_period;
  logic        wr_ctrl, wr_stat, wr_div, wr_tx, rd_rx;

  assign wr_ctrl = avs_write && ack_r && avs_address == OFS_CTRL;
  assign wr_stat = avs_write && ack_r && avs_address == OFS_STAT;
  assign wr_div  = avs_write && ack_r && avs_address == OFS_DIV;
  assign wr_tx   = avs_write && ack_r && avs_address == OFS_TXDATA;
  assign rd_rx   = avs_read && ack_r && avs_address == OFS_RXDATA;
  assign rx_fall = rx_prev_r && !rx_s2_r;
  assign rx_rise = !rx_prev_r && rx_s2_r;

  always_comb begin
    if (ctrl_r[CB_WIDE] && ctrl_r[CB_HSPD]) base_period = 12'(DIV_HH);
    else if (ctrl_r[CB_WIDE] || ctrl_r[CB_HSPD]) base_period = 12'(DIV_ONE);
    else base_period = 12'(DIV_NONE);
  end

  // base tick drives the measuring prescaler and the bit sampler
  uabw_tick #(.W(12)) u_base (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .clr      (!ctrl_r[CB_ENA]),
    .period   (base_period),
    .tick     (bit_tick)
  );
  // measuring clock is base tick over eight
  assign abd_presc_wrap = bit_tick && abd_pre_r == 3'(ABD_RATIO - 1);

  // bus handshake: one wait cycle, then answer; waitrequest idles high from a flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      ack_r           <= (avs_read || avs_write) && !ack_r;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) avs_readdata <= '0;
    else if (ce && avs_read && !ack_r) begin
      unique case (avs_address)
        OFS_CTRL:   avs_readdata <= {24'h000000, ctrl_r};
        OFS_STAT:   avs_readdata <= {26'h0000000, (rx_st_r == RX_IDLE), ovf_r, framing_error_flag_r,
                                     (tx_st_r == TX_IDLE && !txbuf_full_r), txif_r, rxif_r};
        OFS_DIV:    avs_readdata <= {16'h0000, div_r};
        OFS_RXDATA: avs_readdata <= {24'h000000, rxd_r};
        default:    avs_readdata <= '0;
      endcase
    end
  end

  // line synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else if (ce) begin
      rx_s1_r <= lnk.node_tx;
      rx_s2_r <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end
  end

  // control register with hardware clears
  always_ff @(posedge core_clk) begin
    if (rst) ctrl_r <= '0;
    else if (ce) begin
      if (wr_ctrl) ctrl_r <= avs_writedata[7:0];
      // wake only in the asynchronous path, which is all we model
      if (ctrl_r[CB_WAKE] && wake_hold_r && rx_rise) ctrl_r[CB_WAKE] <= 1'b0;
      if (abd_run_r && rx_rise && rise_r == 3'(RISE_COUNT - 1)) ctrl_r[CB_AUTOBAUD_ENABLE] <= 1'b0;
      if (tx_brk_r && tx_st_r == TX_STOP && bit_tick && tx_ph_r == 4'(OVS - 2))
        ctrl_r[CB_SEND_BREAK_REQUEST] <= 1'b0;
      if (!ctrl_r[CB_ENA]) ctrl_r[CB_AUTOBAUD_ENABLE] <= 1'b0;
    end
  end

  // autobaud measurement
  always_ff @(posedge core_clk) begin
    if (rst || !ctrl_r[CB_ENA]) begin
      abd_run_r <= 1'b0;
      rise_r <= '0;
      abd_pre_r <= '0;
      div_r <= DIV_RST;
    end else if (ce) begin
      if (wr_div) div_r <= avs_writedata[15:0];
      if (bit_tick) abd_pre_r <= abd_pre_r + 3'h1;
      // wait out the break when wake is armed
      // first rise after start begins counting
      if (ctrl_r[CB_AUTOBAUD_ENABLE] && !ctrl_r[CB_WAKE] && !abd_run_r && rx_rise) begin
        abd_run_r <= 1'b1;
        rise_r <= 3'h1;
        div_r <= ABD_START;
        abd_pre_r <= '0;
      end else if (abd_run_r) begin
        if (abd_presc_wrap) div_r <= div_r + 16'h0001;
        if (rx_rise) begin
          rise_r <= rise_r + 3'h1;
          if (rise_r == 3'(RISE_COUNT - 1)) abd_run_r <= 1'b0;
        end
        if (!ctrl_r[CB_AUTOBAUD_ENABLE]) abd_run_r <= 1'b0;
      end
    end
  end

  // status flags; hardware set wins over clear
  always_ff @(posedge core_clk) begin
    if (rst || !ctrl_r[CB_ENA]) begin
      ovf_r <= 1'b0;
      rxif_r <= 1'b0;
    end else if (ce) begin
      if (wr_stat && !avs_writedata[SB_OVF] && !ctrl_r[CB_AUTOBAUD_ENABLE]) ovf_r <= 1'b0;
      if (rd_rx) rxif_r <= 1'b0;
      if (abd_run_r && abd_presc_wrap && div_r == 16'hFFFF) ovf_r <= 1'b1;
      if (abd_run_r && rx_rise && rise_r == 3'(RISE_COUNT - 1)) rxif_r <= 1'b1;
      // first low of any char counts
      if (ctrl_r[CB_WAKE] && !wake_hold_r && rx_fall) rxif_r <= 1'b1;
      if (rx_st_r == RX_STOP && bit_tick && rx_ph_r == 4'(OVS - 1)) rxif_r <= 1'b1;
    end
  end

  // wake monitor: falling edge armed the hold
  always_ff @(posedge core_clk) begin
    if (rst || !ctrl_r[CB_WAKE]) wake_hold_r <= 1'b0;
    // falling edge is the wake event
    else if (ce && rx_fall) wake_hold_r <= 1'b1;
  end

  // receiver, 16 ticks a bit, sampled mid-bit
  always_ff @(posedge core_clk) begin
    if (rst || !ctrl_r[CB_ENA] || !ctrl_r[CB_RXEN]) begin
      rx_st_r <= RX_IDLE;
      rx_ph_r <= '0;
      rx_bits_r <= '0;
      rsr_r <= BYTE_RST;
      rxd_r <= BYTE_RST;
      framing_error_flag_r <= 1'b0;
    end else if (ce) begin
      unique case (rx_st_r)
        // held idle under wake or calibration
        RX_IDLE: if (rx_fall && !ctrl_r[CB_WAKE] && !ctrl_r[CB_AUTOBAUD_ENABLE]) begin
          rx_st_r <= RX_START;
          rx_ph_r <= '0;
        end
        RX_START: if (bit_tick) begin
          rx_ph_r <= rx_ph_r + 4'h1;
          if (rx_ph_r == 4'(OVS / 2 - 1)) begin
            rx_ph_r <= '0;
            rx_bits_r <= '0;
            rx_st_r <= rx_s2_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (bit_tick) begin
          rx_ph_r <= rx_ph_r + 4'h1;
          if (rx_ph_r == 4'(OVS - 1)) begin
            rsr_r <= {rx_s2_r, rsr_r[7:1]};
            rx_bits_r <= rx_bits_r + 4'h1;
            if (rx_bits_r == 4'h7) rx_st_r <= RX_STOP;
          end
        end
        RX_STOP: if (bit_tick) begin
          rx_ph_r <= rx_ph_r + 4'h1;
          // a full bit after the last data sample lands mid stop bit
          if (rx_ph_r == 4'(OVS - 1)) begin
            // low stop bit is framing error
            rxd_r <= rsr_r;
            framing_error_flag_r <= !rx_s2_r;
            rx_st_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // transmit buffer and flag
  always_ff @(posedge core_clk) begin
    if (rst || !ctrl_r[CB_ENA]) begin
      txbuf_r <= BYTE_RST;
      txbuf_full_r <= 1'b0;
      txif_r <= 1'b1;
    end else if (ce) begin
      if (tx_st_r == TX_IDLE && txbuf_full_r && bit_tick) txbuf_full_r <= 1'b0;
      if (wr_tx && ctrl_r[CB_TRANSMIT_ENABLE]) begin
        txbuf_r <= avs_writedata[7:0];
        txbuf_full_r <= 1'b1;
      end
      txif_r <= !txbuf_full_r;
    end
  end

  // transmitter: one bit per sixteen ticks
  always_ff @(posedge core_clk) begin
    if (rst || !ctrl_r[CB_ENA]) begin
      tx_st_r <= TX_IDLE;
      tx_ph_r <= '0;
      tx_bits_r <= '0;
      tsr_r <= BYTE_RST;
      tx_brk_r <= 1'b0;
      lnk.dev_tx <= 1'b1;
    end else if (ce && bit_tick) begin
      tx_ph_r <= tx_ph_r + 4'h1;
      unique case (tx_st_r)
        TX_IDLE: begin
          lnk.dev_tx <= 1'b1;
          tx_ph_r <= '0;
          if (txbuf_full_r) begin
            tx_brk_r <= ctrl_r[CB_SEND_BREAK_REQUEST];
            tsr_r <= ctrl_r[CB_SEND_BREAK_REQUEST] ? BYTE_RST : txbuf_r;
            tx_st_r <= TX_START;
            lnk.dev_tx <= 1'b0;
          end
        end
        TX_START: if (tx_ph_r == 4'(OVS - 1)) begin
          tx_st_r <= TX_DATA;
          tx_bits_r <= '0;
          lnk.dev_tx <= tx_brk_r ? 1'b0 : tsr_r[0];
        end
        TX_DATA: if (tx_ph_r == 4'(OVS - 1)) begin
          tx_bits_r <= tx_bits_r + 4'h1;
          tsr_r <= {1'b0, tsr_r[7:1]};
          if (tx_bits_r == (tx_brk_r ? 4'(BREAK_ZEROS - 1) : 4'h7)) begin
            tx_st_r <= TX_STOP;
            lnk.dev_tx <= 1'b1;
          end else lnk.dev_tx <= tx_brk_r ? 1'b0 : tsr_r[1];
        end
        // next byte follows the break
        // idle tick supplies the last sixteenth of the stop bit
        TX_STOP: if (tx_ph_r == 4'(OVS - 2)) begin
          tx_st_r <= TX_IDLE;
          tx_brk_r <= 1'b0;
        end
      endcase
    end
  end
  // shift-empty reported the same for break (status read above)
endmodule // uabw_dev

// ==== core/uabw_pkg.sv ====
package uabw_pkg;
  // clock and tick dividers (core_clk is the oscillator)
  localparam int DIV_HH     = 4;   // base divider, both speed bits
  localparam int DIV_ONE    = 16;  // base divider, one speed bit
  localparam int DIV_NONE   = 64;  // base divider, no speed bit
  localparam int ABD_RATIO  = 8;   // measuring clock is base divided by this
  localparam int OVS        = 16;  // ticks per bit in receiver/transmitter
  localparam int BREAK_ZEROS = 12; // zero bits after the start bit
  localparam int RISE_COUNT  = 5;  // rising edges of the sync byte
  localparam logic [15:0] ABD_START = 16'h0001; // measure begins at one
  localparam logic [15:0] DIV_RST   = 16'h0000;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [7:0]  SYNC_BYTE = 8'h55;
  // register map (word offsets, byte address = offset)
  localparam logic [3:0] OFS_CTRL   = 4'h0;  // control bits
  localparam logic [3:0] OFS_STAT   = 4'h4;  // status bits
  localparam logic [3:0] OFS_DIV    = 4'h8;  // divisor pair
  localparam logic [3:0] OFS_TXDATA = 4'hC;  // transmit data (write)
  localparam logic [3:0] OFS_RXDATA = 4'hC;  // receive data (read)
  // control bit positions
  localparam int CB_TRANSMIT_ENABLE = 0;
  localparam int CB_SEND_BREAK_REQUEST = 1;
  localparam int CB_AUTOBAUD_ENABLE = 2;
  localparam int CB_WAKE = 3;
  localparam int CB_HSPD = 4;
  localparam int CB_WIDE = 5;
  localparam int CB_ENA = 6;
  localparam int CB_RXEN = 7;
  // status bit positions
  localparam int SB_RXIF = 0;
  localparam int SB_TXIF = 1;
  localparam int SB_SHIFT_EMPTY_FLAG = 2;
  localparam int SB_FRAMING_ERROR_FLAG = 3;
  localparam int SB_OVF = 4;
  localparam int SB_RIDL = 5;
endpackage

// ==== core/uabw_if.sv ====
`timescale 1ns/1ps
interface uabw_if;
  logic dev_tx;   // device drives the line toward the node
  logic node_tx;  // node drives the line toward the device
  modport dev  (input node_tx, output dev_tx);
  modport node (input dev_tx, output node_tx);
endinterface // uabw_if

// ==== core/uabw_tick.sv ====
`timescale 1ns/1ps
// divides the clock into one-cycle ticks of a chosen period
module uabw_tick #(
  parameter int W = 12
) (
  input  wire logic         core_clk, // system clock
  input  wire logic         rst,      // sync reset
  input  wire logic         ce,       // clock enable
  input  wire logic         clr,      // restart the period
  input  wire logic [W-1:0] period,   // cycles per tick
  output logic              tick      // one-cycle tick
);
  logic [W-1:0] cnt_r;
  // free count, tick on wrap
  always_ff @(posedge core_clk) begin
    if (rst || clr) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      tick  <= (cnt_r >= period - W'(1));
      cnt_r <= (cnt_r >= period - W'(1)) ? '0 : cnt_r + W'(1);
    end
  end
endmodule // uabw_tick

// ==== core/uabw_node.sv ====
`timescale 1ns/1ps
// remote node: sends a zero wake/break character or a byte on request
module uabw_node
  import uabw_pkg::*;
#(
  parameter int BIT_CYC = 64  // cycles per bit
) (
  input  wire logic       core_clk, // system clock
  input  wire logic       rst,      // sync reset, high
  input  wire logic       ce,       // clock enable
  input  wire logic       send,     // pulse: start a frame
  input  wire logic       brk,      // frame is a 13-bit zero character
  input  wire logic [7:0] data,     // byte to send when not break
  output logic            busy,     // frame in progress
  output logic            rx_bit,   // synchronised device line
  uabw_if.node            lnk       // serial line
);
  logic [15:0] cyc_r;
  logic [3:0]  idx_r;
  logic [3:0]  last_r;
  logic [9:0]  sh_r;
  logic        s1_r;
  // sample device line through two flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_r <= 1'b1;
      rx_bit <= 1'b1;
    end else if (ce) begin
      s1_r <= lnk.dev_tx;
      rx_bit <= s1_r;
    end
  end
  // wake char is thirteen zero bits
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
      cyc_r <= '0;
      idx_r <= '0;
      last_r <= '0;
      sh_r <= '1;
      lnk.node_tx <= 1'b1;
    end else if (ce) begin
      if (!busy) begin
        lnk.node_tx <= 1'b1;
        if (send) begin
          busy <= 1'b1;
          cyc_r <= '0;
          idx_r <= '0;
          last_r <= brk ? 4'hD : 4'h9;
          sh_r <= brk ? 10'h000 : {1'b1, data, 1'b0};
          lnk.node_tx <= 1'b0;
        end
      end else if (cyc_r == 16'(BIT_CYC - 1)) begin
        cyc_r <= '0;
        idx_r <= idx_r + 4'h1;
        sh_r <= {1'b0, sh_r[9:1]}; // zero fill keeps a break low to the end
        if (idx_r == last_r) begin
          busy <= 1'b0;
          lnk.node_tx <= 1'b1;
        end else lnk.node_tx <= (idx_r + 4'h1 == last_r) ? 1'b1 : sh_r[1];
      end else cyc_r <= cyc_r + 16'h0001;
    end
  end
endmodule // uabw_node

// ==== tb/uabw_sva.sv ====
`timescale 1ns/1ps
// watches frame timing on both directions of the serial line
module uabw_sva #(
  parameter int BIT = 64   // cycles per bit
) (
  input wire logic core_clk, // system clock
  input wire logic rst,      // sync reset, high
  input wire logic dev_tx,   // device toward node
  input wire logic node_tx   // node toward device
);
  logic [15:0] d_low_r;
  logic [15:0] d_high_r;
  logic [15:0] n_low_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // length of the current low run on the device line
  always_ff @(posedge core_clk) begin
    if (rst || dev_tx) d_low_r <= 16'h0000;
    else d_low_r <= d_low_r + 16'h0001;
  end

  // length of the current high run on the device line, saturating
  always_ff @(posedge core_clk) begin
    if (rst || !dev_tx) d_high_r <= 16'h0000;
    else if (d_high_r != 16'hFFFF) d_high_r <= d_high_r + 16'h0001;
  end

  // length of the current low run on the node line
  always_ff @(posedge core_clk) begin
    if (rst || node_tx) n_low_r <= 16'h0000;
    else n_low_r <= n_low_r + 16'h0001;
  end

  property p_rst_idle; $fell(rst) |-> dev_tx && node_tx; endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("line not idle after reset");
  property p_dbrk_max; d_low_r <= 16'(13 * BIT); endproperty
  a_dbrk_max: assert property (p_dbrk_max)
    else $error("device low run longer than a break");
  property p_dbrk_len; $rose(dev_tx) && d_low_r > 16'(10 * BIT) |-> d_low_r >= 16'(13 * BIT - 2);
  endproperty
  a_dbrk_len: assert property (p_dbrk_len)
    else $error("device break shorter than thirteen low bits");
  property p_dbit_min; $rose(dev_tx) |-> d_low_r >= 16'(BIT - 2); endproperty
  a_dbit_min: assert property (p_dbit_min)
    else $error("device low pulse shorter than one bit");
  property p_dstop; $fell(dev_tx) |-> d_high_r >= 16'(BIT - 2); endproperty
  a_dstop: assert property (p_dstop)
    else $error("device stop bit shorter than one bit");
  property p_nbrk_max; n_low_r <= 16'(13 * BIT); endproperty
  a_nbrk_max: assert property (p_nbrk_max)
    else $error("node low run longer than a break");
  property p_nbrk_len; $rose(node_tx) && n_low_r > 16'(10 * BIT) |-> n_low_r >= 16'(13 * BIT - 2);
  endproperty
  a_nbrk_len: assert property (p_nbrk_len)
    else $error("node wake character too short");
  property p_nbit_min; $rose(node_tx) |-> n_low_r >= 16'(BIT - 2); endproperty
  a_nbit_min: assert property (p_nbit_min)
    else $error("node low pulse shorter than one bit");
endmodule // uabw_sva

// ==== tb/uabw_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module uabw_tb_top;
  import uabw_pkg::*;
  localparam int          BIT   = 64; // both speed bits: base 4, 16 ticks a bit
  localparam logic [31:0] BASE  = (32'h1 << CB_ENA) | (32'h1 << CB_HSPD) | (32'h1 << CB_WIDE);
  localparam logic [31:0] TRANSMIT_ENABLE  = 32'h1 << CB_TRANSMIT_ENABLE;
  localparam logic [31:0] SEND_BREAK_REQUEST = 32'h1 << CB_SEND_BREAK_REQUEST;
  localparam logic [31:0] AUTOBAUD_ENABLE = 32'h1 << CB_AUTOBAUD_ENABLE;
  localparam logic [31:0] WAKE  = 32'h1 << CB_WAKE;
  localparam logic [31:0] RXEN  = 32'h1 << CB_RXEN;
  logic        core_clk, rst, ce, avs_read, avs_write, avs_waitrequest;
  logic        node_send, node_brk, node_busy;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  node_data;
  int          error_cnt, checks_done;
  int          cyc = 0;

  uabw_if uabw_if_i ();
  uabw_dev uabw_dev_i (.core_clk(core_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(uabw_if_i));
  uabw_node #(.BIT_CYC(BIT)) uabw_node_i (.core_clk(core_clk), .rst(rst), .ce(ce),
    .send(node_send), .brk(node_brk), .data(node_data), .busy(node_busy), .rx_bit(),
    .lnk(uabw_if_i));
  uabw_sva #(.BIT(BIT)) uabw_sva_i (.core_clk(core_clk), .rst(rst),
    .dev_tx(uabw_if_i.dev_tx), .node_tx(uabw_if_i.node_tx));

  // clock generation
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task end_sim;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // cycle watchdog against hangs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end

  // bus cycles: wait is sampled on the settled value just ahead of each edge
  task av_rd(input logic [3:0] a, output logic [31:0] d);
    logic w;
    @(posedge core_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do begin
      @(negedge core_clk);
      w = avs_waitrequest;
      d = avs_readdata;
      @(posedge core_clk);
    end while (w !== 1'b0);
    avs_read <= 1'b0;
  endtask

  task av_wr(input logic [3:0] a, input logic [31:0] d);
    logic w;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do begin
      @(negedge core_clk);
      w = avs_waitrequest;
      @(posedge core_clk);
    end while (w !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task poll(input logic [3:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      av_rd(a, rd);
      n++;
    end while (rd[b] !== v && n < 3000);
    `CHK(rd[b], v)
  endtask

  task wait_line(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (uabw_if_i.dev_tx !== v && n < 3000);
    `CHK(uabw_if_i.dev_tx, v)
  endtask

  // node frame request, only while the node is idle
  task node_send_frame(input logic b, input logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (node_busy !== 1'b0 && n < 3000);
    `CHK(node_busy, 1'b0)
    @(posedge core_clk);
    node_send <= 1'b1;
    node_brk  <= b;
    node_data <= d;
    @(posedge core_clk);
    node_send <= 1'b0;
  endtask

  // reset values, unmapped read, flags after enable
  task sc_reset;
    av_rd(OFS_DIV, rd);
    `CHK(rd[15:0], DIV_RST)
    av_rd(4'h2, rd);
    `CHK(rd, 32'h00000000)
    av_wr(OFS_CTRL, BASE | TRANSMIT_ENABLE);
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_TXIF], 1'b1)
    `CHK(rd[SB_SHIFT_EMPTY_FLAG], 1'b1)
  endtask

  // break with a dummy value, then preloaded sync byte
  task sc_break_tx;
    time         t0;
    int          i;
    logic [7:0]  b;
    av_wr(OFS_CTRL, BASE | TRANSMIT_ENABLE | SEND_BREAK_REQUEST);
    av_wr(OFS_TXDATA, 32'h000000FF);
    wait_line(1'b0);
    t0 = $time;
    av_wr(OFS_TXDATA, {24'h000000, SYNC_BYTE});
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_SHIFT_EMPTY_FLAG], 1'b0)
    wait_line(1'b1);
    `CHK(int'(($time - t0) / 100), (BREAK_ZEROS + 1) * BIT)
    t0 = $time;
    wait_line(1'b0);
    `CHK(int'(($time - t0) / 100), BIT)
    repeat (BIT / 2) @(negedge core_clk);
    for (i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge core_clk);
      b[i] = uabw_if_i.dev_tx;
    end
    `CHK(b, SYNC_BYTE)
    av_rd(OFS_CTRL, rd);
    `CHK(rd[CB_SEND_BREAK_REQUEST], 1'b0)
    poll(OFS_STAT, SB_SHIFT_EMPTY_FLAG, 1'b1);
    `CHK(rd[SB_TXIF], 1'b1)
  endtask

  // break received by the ordinary receiver
  task sc_break_rx;
    av_wr(OFS_CTRL, BASE | RXEN);
    node_send_frame(1'b1, 8'hA5);
    poll(OFS_STAT, SB_RXIF, 1'b1);
    `CHK(rd[SB_FRAMING_ERROR_FLAG], 1'b1)
    av_rd(OFS_RXDATA, rd);
    `CHK(rd[7:0], 8'h00)
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_RXIF], 1'b0)
  endtask

  // wake armed, nonzero character: first low is the wake, rest is dropped
  task sc_wake_char;
    av_wr(OFS_CTRL, BASE | RXEN | WAKE);
    node_send_frame(1'b0, 8'hF0);
    repeat (12 * BIT) @(posedge core_clk);
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_RXIF], 1'b1)
    `CHK(rd[SB_RIDL], 1'b1)
    av_rd(OFS_CTRL, rd);
    `CHK(rd[CB_WAKE], 1'b0)
    av_rd(OFS_RXDATA, rd);
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_RXIF], 1'b0)
  endtask

  // wake on break, then measure the sync byte after it
  task sc_wake_abd;
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_RIDL], 1'b1)
    av_wr(OFS_CTRL, BASE | RXEN | WAKE | AUTOBAUD_ENABLE);
    node_send_frame(1'b1, 8'h00);
    repeat (5 * BIT) @(posedge core_clk);
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_RXIF], 1'b1)
    av_rd(OFS_CTRL, rd);
    `CHK(rd[CB_WAKE], 1'b1)
    av_rd(OFS_RXDATA, rd);
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_RXIF], 1'b0)
    node_send_frame(1'b0, SYNC_BYTE);
    av_rd(OFS_CTRL, rd);
    `CHK(rd[CB_WAKE], 1'b0)
    `CHK(rd[CB_AUTOBAUD_ENABLE], 1'b1)
    poll(OFS_CTRL, CB_AUTOBAUD_ENABLE, 1'b0);
    av_rd(OFS_STAT, rd);
    `CHK(rd[SB_RXIF], 1'b1)
    av_rd(OFS_DIV, rd);
    // eight bits of 64 cycles at one count per 32 cycles, from one
    `CHK((rd[15:0] >= 16'h0010 && rd[15:0] <= 16'h0012), 1'b1)
  endtask

  // main sequence
  initial begin
    rst           = 1'b1;
    ce            = 1'b1;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 4'h0;
    avs_writedata = 32'h00000000;
    node_send     = 1'b0;
    node_brk      = 1'b0;
    node_data     = 8'h00;
    error_cnt     = 0;
    checks_done   = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (100) @(posedge core_clk);
    sc_reset();
    sc_break_tx();
    sc_break_rx();
    sc_wake_char();
    sc_wake_abd();
    end_sim();
  end
endmodule // uabw_tb_top
